// ---- hdl/svmc_top.v ----
// Supply voltage monitor control, status register and sampling scheduler.
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`include "svmc_regs.vh"
module svmc_top #(
	parameter LVR_ENABLE = 0, // Low-voltage reset option.
	parameter TICK_DIV = `SVMC_TICK_DIV, // System clocks per 2048 Hz tick.
	parameter AUTO_TICKS = `SVMC_AUTO_TICKS // Ticks between auto samplings.
) (
	input wire mclk, // System clock, 20 MHz.
	input wire reset, // Asynchronous reset, active high.
	input wire [15:0] addr, // Register address.
	input wire [7:0] wdata, // Write data.
	input wire wr, // Write strobe.
	input wire rd, // Read strobe.
	output reg [7:0] rdata, // Read data, one cycle after rd.
	input wire sleep_instruction, // Level: held high while the sleep instruction is in effect.
	output reg osc_stop_ok, // Low-speed oscillator may stop.
	input wire cmp_in, // Asynchronous comparator output.
	output reg [3:0] trial_code, // Trial code to the ladder.
	output reg lvr_reset // Internal low-voltage reset request.
);
	localparam ST_INIT = 3'b001;
	localparam ST_RUN = 3'b010;
	localparam ST_SLEEP = 3'b100;

	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg auto_r;
	reg cont_r;
	reg [15:0] div_r;
	reg tick_r;
	reg [14:0] auto_cnt_r;
	reg auto_due_r;
	reg [3:0] level_r;
	reg [2:0] zero_cnt_r;
	reg lvr_r;
	reg saved_cont_r;
	reg saved_auto_r;
	wire cmp_s;
	wire [3:0] sar_code;
	wire sar_busy;
	wire sar_done;
	wire [3:0] sar_result;
	wire sel_ctrl;
	wire start_req;

	assign sel_ctrl = (addr == `SVMC_CTRL_ADDR);
	// Continuous wins over auto and chains samplings; auto and the first sampling need an idle sampler.
	assign start_req = (state_r == ST_INIT && !sar_busy) ||
		(state_r == ST_RUN && (cont_r || (auto_due_r && !sar_busy)));

	svmc_sync u_sync (
		.mclk(mclk),
		.reset(reset),
		.din(cmp_in),
		.dout(cmp_s)
	);

	svmc_sar u_sar (
		.mclk(mclk),
		.reset(reset),
		.tick(tick_r),
		.start(start_req),
		.cmp_high(cmp_s),
		.trial_code(sar_code),
		.busy(sar_busy),
		.done(sar_done),
		.result(sar_result)
	);

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			div_r <= 16'h0000;
			tick_r <= 1'b0;
		end else begin
			tick_r <= 1'b0;
			if (div_r == TICK_DIV[15:0] - 16'h0001) begin
				div_r <= 16'h0000;
				tick_r <= 1'b1;
			end else begin
				div_r <= div_r + 16'h0001;
			end
		end
	end

	// Auto period counter; a missed start stays due until the sampler takes it.
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			auto_cnt_r <= 15'h0000;
			auto_due_r <= 1'b0;
		end else if (!auto_r || cont_r) begin
			auto_cnt_r <= 15'h0000;
			auto_due_r <= auto_r && !cont_r;
		end else if (tick_r) begin
			if (!sar_busy && auto_due_r && state_r == ST_RUN)
				auto_due_r <= 1'b0;
			if (auto_cnt_r == AUTO_TICKS[14:0] - 15'h0001) begin
				auto_cnt_r <= 15'h0000;
				auto_due_r <= 1'b1;
			end else begin
				auto_cnt_r <= auto_cnt_r + 15'h0001;
			end
		end
	end

	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_INIT: begin
				if (sar_done)
					state_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (sleep_instruction)
					state_nxt = ST_SLEEP;
			end
			ST_SLEEP: begin
				if (!sleep_instruction && !sar_busy)
					state_nxt = ST_RUN;
			end
			default: state_nxt = ST_INIT;
		endcase
	end

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_r <= ST_INIT;
			cont_r <= 1'b0;
			auto_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (state_r == ST_SLEEP || (state_r == ST_RUN && sleep_instruction)) begin
				cont_r <= 1'b0;
				auto_r <= 1'b0;
			end else if (lvr_r) begin
				cont_r <= 1'b1;
			end else if (LVR_ENABLE != 0 && lvr_reset && !lvr_r) begin
				cont_r <= saved_cont_r;
				auto_r <= saved_auto_r;
			end else if (wr && sel_ctrl) begin
				cont_r <= wdata[`SVMC_CONT_BIT];
				auto_r <= wdata[`SVMC_AUTO_BIT];
			end
		end
	end

	// Oscillator may stop only in sleep once no sampling is running.
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			osc_stop_ok <= 1'b0;
		end else begin
			osc_stop_ok <= (state_r == ST_SLEEP) && !sar_busy && sleep_instruction;
		end
	end

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			level_r <= 4'h0;
		end else if (sar_done) begin
			level_r <= sar_result;
		end
	end

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			zero_cnt_r <= 3'h0;
			lvr_r <= 1'b0;
			lvr_reset <= 1'b0;
			saved_cont_r <= 1'b0;
			saved_auto_r <= 1'b0;
		end else begin
			lvr_reset <= lvr_r;
			if (LVR_ENABLE != 0 && sar_done) begin
				if (sar_result == 4'h0) begin
					if (zero_cnt_r != 3'h7)
						zero_cnt_r <= zero_cnt_r + 3'h1;
					if (!lvr_r && {29'h0, zero_cnt_r} == `SVMC_LVR_COUNT - 1) begin
						lvr_r <= 1'b1;
						saved_cont_r <= cont_r;
						saved_auto_r <= auto_r;
					end
				end else begin
					zero_cnt_r <= 3'h0;
					if (sar_result >= `SVMC_LVR_RELEASE)
						lvr_r <= 1'b0;
				end
			end
		end
	end

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			trial_code <= 4'h0;
		end else begin
			trial_code <= sar_code;
		end
	end

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			rdata <= 8'h00;
		end else if (rd && sel_ctrl) begin
			// Bit 4 reads busy, or high in ST_INIT; a stopped mode keeps it high until the sampler ends.
			rdata <= {2'b00, auto_r, sar_busy || state_r == ST_INIT, level_r};
		end else begin
			rdata <= 8'h00;
		end
	end
endmodule

// ---- hdl/svmc_regs.vh ----
// Register offsets, field positions and timing counts for the supply monitor controller.
`ifndef SVMC_REGS_VH
`define SVMC_REGS_VH
`define SVMC_ADDR_W 16
`define SVMC_CTRL_ADDR 16'hFF12
`define SVMC_AUTO_BIT 5
`define SVMC_CONT_BIT 4
`define SVMC_LEVEL_HI 3
`define SVMC_LEVEL_LO 0
`define SVMC_CLK_HZ 20000000
`define SVMC_TICK_HZ 2048
`define SVMC_TICK_DIV ((`SVMC_CLK_HZ + `SVMC_TICK_HZ - 1) / `SVMC_TICK_HZ)
`define SVMC_SAMPLE_TICKS 16
`define SVMC_STEP_TICKS 4
`define SVMC_AUTO_PERIOD_S 4
`define SVMC_AUTO_TICKS (`SVMC_AUTO_PERIOD_S * `SVMC_TICK_HZ)
`define SVMC_LVR_COUNT 4
`define SVMC_LVR_RELEASE 4'h2
`endif

// ---- hdl/svmc_sync.v ----
// Three-stage synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/10ps
module svmc_sync (
	input wire mclk, // System clock.
	input wire reset, // Asynchronous reset, active high.
	input wire din, // Asynchronous input.
	output reg dout // Filtered synchronous level.
);
	reg s1_r;
	reg s2_r;
	reg s3_r;
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				dout <= s3_r;
		end
	end
endmodule

// ---- hdl/svmc_sar.v ----
// Four-step successive-approximation engine driven by the sampling tick.
`timescale 1ns/10ps
`include "svmc_regs.vh"
module svmc_sar (
	input wire mclk, // System clock.
	input wire reset, // Asynchronous reset, active high.
	input wire tick, // One-cycle 2048 Hz tick.
	input wire start, // Begin a sampling on this tick.
	input wire cmp_high, // Comparator: supply above trial level.
	output reg [3:0] trial_code, // Trial code to the ladder.
	output reg busy, // Sampling in progress.
	output reg done, // One-cycle pulse when result is ready.
	output reg [3:0] result // Last completed result.
);
	reg [3:0] tick_cnt_r;
	reg [1:0] bit_r;
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			tick_cnt_r <= 4'h0;
			bit_r <= 2'h3;
			trial_code <= 4'h0;
			busy <= 1'b0;
			done <= 1'b0;
			result <= 4'h0;
		end else begin
			done <= 1'b0;
			if (tick) begin
				if (!busy) begin
					if (start) begin
						busy <= 1'b1;
						tick_cnt_r <= 4'h0;
						bit_r <= 2'h3;
						trial_code <= 4'h8;
					end
				end else begin
					tick_cnt_r <= tick_cnt_r + 4'h1;
					// A step resolves on the last tick of each quarter of the sampling.
					if (tick_cnt_r[1:0] == 2'h3) begin
						if (bit_r == 2'h0) begin
							result <= {trial_code[3:1], cmp_high};
							done <= 1'b1;
							if (start) begin
								// A pending request chains the next sampling with no idle tick.
								tick_cnt_r <= 4'h0;
								bit_r <= 2'h3;
								trial_code <= 4'h8;
							end else begin
								busy <= 1'b0;
								trial_code <= 4'h0;
							end
						end else begin
							trial_code[bit_r] <= cmp_high;
							trial_code[bit_r - 2'h1] <= 1'b1;
							bit_r <= bit_r - 2'h1;
						end
					end
				end
			end
		end
	end
endmodule

// ---- verification/svmc_top_monitor.sv ----
// Port checker for the supply monitor controller.
`timescale 1ns/10ps
module svmc_top_monitor #(
	parameter LVR_ENABLE = 0 // Low-voltage reset option.
) (
	input wire mclk, // Clock.
	input wire reset, // Reset.
	input wire [15:0] addr, // Address.
	input wire [7:0] wdata, // Write data.
	input wire wr, // Write strobe.
	input wire rd, // Read strobe.
	input wire [7:0] rdata, // Read data.
	input wire sleep_instruction, // Sleep.
	input wire osc_stop_ok, // Stop grant.
	input wire [3:0] trial_code, // Trial code.
	input wire lvr_reset // Reset request.
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	property p_rdata_zero;
		!($past(rd) && $past(addr) == 16'hFF12) |-> rdata == 8'h00;
	endproperty
	a_rdata_zero: assert property (p_rdata_zero) else $error("rdata not zero");
	property p_high_zero;
		rdata[7:6] == 2'b00;
	endproperty
	a_high_zero: assert property (p_high_zero) else $error("upper bits set");
	property p_auto_rdbk;
		wr && addr == 16'hFF12 && !sleep_instruction ##1 !wr ##1
			rd && addr == 16'hFF12 && !sleep_instruction |=> rdata[5] == $past(wdata[5], 3);
	endproperty
	a_auto_rdbk: assert property (p_auto_rdbk) else $error("auto bit readback");
	property p_sleep_clear;
		$past(rd) && $past(sleep_instruction) && $past(sleep_instruction, 2) |-> !rdata[5];
	endproperty
	a_sleep_clear: assert property (p_sleep_clear) else $error("auto bit in sleep");
	property p_osc_sleep;
		osc_stop_ok |-> $past(sleep_instruction);
	endproperty
	a_osc_sleep: assert property (p_osc_sleep) else $error("stop without sleep");
	property p_osc_hold;
		osc_stop_ok && $past(osc_stop_ok) |-> $stable(trial_code);
	endproperty
	a_osc_hold: assert property (p_osc_hold) else $error("sampling while stopped");
	property p_lvr_off;
		LVR_ENABLE == 0 |-> !lvr_reset;
	endproperty
	a_lvr_off: assert property (p_lvr_off) else $error("reset without option");
	property p_trial_start;
		$past(trial_code) == 4'h0 && trial_code != 4'h0 |-> trial_code == 4'h8;
	endproperty
	a_trial_start: assert property (p_trial_start) else $error("trial not MSB first");
endmodule
bind svmc_top svmc_top_monitor #(.LVR_ENABLE(LVR_ENABLE)) svmc_top_monitor_i (.mclk(mclk),
	.reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.sleep_instruction(sleep_instruction), .osc_stop_ok(osc_stop_ok),
	.trial_code(trial_code), .lvr_reset(lvr_reset));

// ---- verification/testbench.sv ----
// Self-checking testbench for the supply monitor controller.
`timescale 1ns/10ps
module testbench;
	reg mclk = 0, reset = 1, wr = 0, rd = 0, sleep_instruction = 0, cmp_in = 0, rd_q = 0;
	reg [15:0] addr = 0, q_e;
	reg [7:0] wdata = 0, v = 0;
	reg [3:0] lvl = 4'h5, old;
	reg [15:0] expq[$];
	wire [7:0] rdata;
	wire [3:0] trial_code;
	wire osc_stop_ok, lvr_reset;
	integer errors = 0, checks = 0, seed = 32'h0f7d, n;
	svmc_top #(.TICK_DIV(4), .AUTO_TICKS(40)) svmc_top_i (.mclk(mclk), .reset(reset),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.sleep_instruction(sleep_instruction), .osc_stop_ok(osc_stop_ok), .cmp_in(cmp_in),
		.trial_code(trial_code), .lvr_reset(lvr_reset));
	always #25 mclk = ~mclk;
	always @(posedge mclk) cmp_in <= (lvl >= trial_code);
	// Each note holds a mask in the upper byte and the expected bits below it.
	always @(posedge mclk) begin
		if (rd_q && expq.size() > 0) begin
			q_e = expq.pop_front();
			if (q_e[15:8] != 8'h00) begin
				checks = checks + 1;
				if ((rdata & q_e[15:8]) !== q_e[7:0]) begin
					errors = errors + 1;
					$display("mismatch at %0t: read %h note %h", $time, rdata, q_e);
				end
			end
		end
		rd_q <= rd;
	end
	task chk(input ok);
		begin
			checks = checks + 1;
			if (ok !== 1'b1) begin
				errors = errors + 1;
				$display("mismatch at %0t: status check", $time);
			end
		end
	endtask
	task wreg(input [7:0] d);
		begin
			@(posedge mclk);
			wr <= 1;
			addr <= 16'hFF12;
			wdata <= d;
			@(posedge mclk);
			wr <= 0;
		end
	endtask
	task rreg(input [15:0] a, input [15:0] me);
		begin
			@(posedge mclk);
			rd <= 1;
			addr <= a;
			expq.push_back(me);
			@(posedge mclk);
			rd <= 0;
			#1 v = rdata;
		end
	endtask
	task wait_busy(input b);
		begin
			n = 0;
			v[4] = ~b;
			while (v[4] !== b && n < 200) begin
				rreg(16'hFF12, 16'h0000);
				n = n + 1;
			end
			chk(n < 200);
		end
	endtask
	task end_sim;
		begin
			$display("errors %0d checks %0d", errors, checks);
			if (errors == 0 && checks > 0) $display("All tests passed");
			else $display("Some tests failed");
			$finish;
		end
	endtask
	initial begin
		#2000000;
		errors = errors + 1;
		end_sim;
	end
	initial begin
		repeat (3) @(posedge mclk);
		reset <= 0;
		rreg(16'hFF12, 16'hF010);
		wait_busy(0);
		rreg(16'hFF12, {8'hFF, 4'h0, lvl});
		rreg(16'hFF11, 16'hFF00);
		lvl = $random(seed);
		wreg(($random(seed) & 8'hCF) | 8'h20);
		rreg(16'hFF12, 16'hE020);
		wait_busy(1);
		wait_busy(0);
		rreg(16'hFF12, {8'hEF, 4'h2, lvl});
		old = lvl;
		lvl = ~lvl;
		rreg(16'hFF12, {8'h0F, 4'h0, old});
		wait_busy(1);
		wreg(8'h00);
		rreg(16'hFF12, 16'hF010);
		wait_busy(0);
		repeat (100) rreg(16'hFF12, {8'hFF, 4'h0, lvl});
		lvl = $random(seed);
		wreg(8'h30);
		repeat (150) @(posedge mclk);
		rreg(16'hFF12, {8'h2F, 4'h2, lvl});
		lvl = $random(seed);
		repeat (150) @(posedge mclk);
		rreg(16'hFF12, {8'h2F, 4'h2, lvl});
		repeat (40) rreg(16'hFF12, 16'h1010);
		// A trial code of 8 after any other value marks the start of a fresh sampling.
		wait (trial_code != 4'h8);
		wait (trial_code == 4'h8);
		@(posedge mclk);
		sleep_instruction <= 1;
		repeat (8) @(posedge mclk);
		chk(!osc_stop_ok);
		rreg(16'hFF12, 16'h3010);
		n = 0;
		while (osc_stop_ok !== 1'b1 && n < 100) begin
			#50 n = n + 1;
		end
		chk(osc_stop_ok);
		wreg(8'h30);
		rreg(16'hFF12, 16'hF000);
		@(posedge mclk);
		sleep_instruction <= 0;
		repeat (100) @(posedge mclk);
		rreg(16'hFF12, 16'hF000);
		end_sim;
	end
endmodule
